// ==== agk_consts.vh ====
// Function
// (R01) Config bits 7:6 select controller clock: 6, 8, 12 or 16 MHz.
// (R02) Config bit 2 lets the fast port drive gate and reset outputs.
// (R03) Config bit 1 gives the address gate to command snooping logic.
// (R04) Config bit 0 gives keyboard reset to command snooping logic.
// (R05) Data byte after write-output-port command sets gate from bit 1.
// (R06) Data byte after write-output-port command sets reset from bit 0.
// (R07) Pulse-reset command: wait 14 us, then reset low at least 6 us.
// (R08) Each output driven by software or snooping logic, never both.
// (R09) With fast port enabled its requests merge with controller sources.
// (R10) Fast port resets to 0x24; bits 5,2 read 1; 7,6,4,3 read 0.
// (R11) Fast port bit 1 drives the address gate high or low.
// (R12) Fast port bit 0 rising: after 14 us, reset low for 6 us.
// (R13) Host clears reset request bit before another; only 0-to-1 triggers.
// (R14) Delay and pulse counted in cycles scaled by selected clock rate.
// (R15) Reset low if either source asks; gate is OR of both sources.
`ifndef AGK_CONSTS_VH
`define AGK_CONSTS_VH
`define AGK_CFG_OFFSET   8'hf0
`define AGK_CFG_CLK_HI   7
`define AGK_CFG_CLK_LO   6
`define AGK_CFG_FAST_EN  2
`define AGK_CFG_HW_GATE  1
`define AGK_CFG_HW_RST   0
`define AGK_CFG_RESET    8'h00
`define AGK_FAST_RESET   8'h24
`define AGK_FAST_ONES    8'h24
`define AGK_FAST_GATE    1
`define AGK_FAST_RST     0
`define AGK_CMD_WR_OUT   8'hd1
`define AGK_CMD_PULSE    8'hfe
`define AGK_DELAY_NS     14000
`define AGK_PULSE_NS     6000
`define AGK_MHZ_6        6
`define AGK_MHZ_8        8
`define AGK_MHZ_12       12
`define AGK_MHZ_16       16
`endif

// ==== agk_pulse.v ====
`timescale 1ns/1ps
`include "agk_consts.vh"
// delay-then-low-pulse sequencer, counts in controller clock cycles
module agk_pulse #(
	parameter CW = 10
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// control
	input  wire          start_i,
	input  wire [CW-1:0] delay_cyc_i,
	input  wire [CW-1:0] pulse_cyc_i,
	// result
	output reg           low_o
);
	localparam S_IDLE  = 2'd0;
	localparam S_WAIT  = 2'd1;
	localparam S_PULSE = 2'd2;

	reg [1:0]    st_q;
	reg [CW-1:0] cnt_q;

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q  <= S_IDLE;
			cnt_q <= {CW{1'b0}};
			low_o <= 1'b0;
		end else begin
			case (st_q)
			S_IDLE: begin
				low_o <= 1'b0;
				if (start_i) begin
					st_q  <= S_WAIT;
					cnt_q <= delay_cyc_i;
				end
			end
			S_WAIT: begin
				if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
					st_q  <= S_PULSE;
					cnt_q <= pulse_cyc_i;
					low_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
				end
			end
			S_PULSE: begin
				// count down to zero so the low level lasts the full pulse count
				if (cnt_q == {CW{1'b0}}) begin
					st_q  <= S_IDLE;
					low_o <= 1'b0;
				end else begin
					cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
				end
			end
			default: begin
				st_q  <= S_IDLE;
				low_o <= 1'b0;
			end
			endcase
		end
	end
endmodule // agk_pulse

// ==== agk_gate_reset.v ====
`timescale 1ns/1ps
`include "agk_consts.vh"
module agk_gate_reset #(
	parameter CW = 10
) (
	// clock and reset
	input  wire       clk_i,
	input  wire       nrst_i,
	// configuration register port
	input  wire       cfg_wr_i,
	input  wire [7:0] cfg_addr_i,
	input  wire [7:0] cfg_wdata_i,
	output wire [7:0] cfg_rdata_o,
	// fast control port
	input  wire       fast_wr_i,
	input  wire [7:0] fast_wdata_i,
	output wire [7:0] fast_rdata_o,
	// keyboard controller input stream
	input  wire       kbc_cmd_wr_i,
	input  wire       kbc_data_wr_i,
	input  wire [7:0] kbc_byte_i,
	// software driven levels from the controller firmware
	input  wire       sw_addr_gate_i,
	input  wire       sw_kbd_reset_n_i,
	// outputs
	output reg        addr_line20_gate_o,
	output reg        keyboard_reset_out_n_o,
	output wire [1:0] ctrl_clock_sel_o
);
	reg  [7:0]    cfg_q;
	reg           soft_addr_gate_value_q;
	reg           fast_reset_request_q;
	reg           wr_out_pend_q;
	reg           hw_gate_q;
	reg           hw_rst_n_q;
	reg  [CW-1:0] delay_cyc;
	reg  [CW-1:0] pulse_cyc;

	// full-width cycle counts per rate, cut to the counter width on purpose
	// 6 MHz rate
	wire [31:0]   dly6_w = `AGK_DELAY_NS * `AGK_MHZ_6 / 1000;
	wire [31:0]   pls6_w = `AGK_PULSE_NS * `AGK_MHZ_6 / 1000;

	// 8 MHz rate
	wire [31:0]   dly8_w = `AGK_DELAY_NS * `AGK_MHZ_8 / 1000;
	wire [31:0]   pls8_w = `AGK_PULSE_NS * `AGK_MHZ_8 / 1000;

	// 12 MHz rate
	wire [31:0]   dly12_w = `AGK_DELAY_NS * `AGK_MHZ_12 / 1000;
	wire [31:0]   pls12_w = `AGK_PULSE_NS * `AGK_MHZ_12 / 1000;

	// 16 MHz rate, the largest counts: CW must hold 224
	wire [31:0]   dly16_w = `AGK_DELAY_NS * `AGK_MHZ_16 / 1000;
	wire [31:0]   pls16_w = `AGK_PULSE_NS * `AGK_MHZ_16 / 1000;

	// config decode
	wire          fast_port_enable    = cfg_q[`AGK_CFG_FAST_EN];
	wire          hw_addr_gate_select = cfg_q[`AGK_CFG_HW_GATE];
	wire          hw_kbd_reset_select = cfg_q[`AGK_CFG_HW_RST];
	wire          cfg_hit = cfg_wr_i && (cfg_addr_i == `AGK_CFG_OFFSET);
	wire          pulse_cmd = kbc_cmd_wr_i && (kbc_byte_i == `AGK_CMD_PULSE);
	wire          fast_rise;
	wire          hw_pulse_low;
	wire          fast_pulse_low;
	reg           ctl_gate;
	reg           ctl_rst_n;

	assign ctrl_clock_sel_o = cfg_q[`AGK_CFG_CLK_HI:`AGK_CFG_CLK_LO]; // R01
	assign cfg_rdata_o      = cfg_q;
	// reserved bits are forced, only the two live bits are stored
	assign fast_rdata_o = `AGK_FAST_ONES | {6'h00, soft_addr_gate_value_q,
		fast_reset_request_q}; // R10
	// only a fresh 0-to-1 write of the request bit starts a pulse
	assign fast_rise = fast_wr_i && fast_port_enable && fast_wdata_i[`AGK_FAST_RST]
		&& !fast_reset_request_q; // R13

	// cycle counts per selected rate: integer division truncates, exact at all four rates
	always @* begin
		case (ctrl_clock_sel_o) // R14
		2'b00: begin
			delay_cyc = dly6_w[CW-1:0];
			pulse_cyc = pls6_w[CW-1:0];
		end

		2'b01: begin
			delay_cyc = dly8_w[CW-1:0];
			pulse_cyc = pls8_w[CW-1:0];
		end

		2'b10: begin
			delay_cyc = dly12_w[CW-1:0];
			pulse_cyc = pls12_w[CW-1:0];
		end

		// select 2'b11 lands here: the 16 MHz counts, the largest of the four rates
		default: begin
			delay_cyc = dly16_w[CW-1:0];
			pulse_cyc = pls16_w[CW-1:0];
		end
		endcase
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_q                  <= `AGK_CFG_RESET;
			soft_addr_gate_value_q <= 1'b0;
			fast_reset_request_q   <= 1'b0;
			wr_out_pend_q          <= 1'b0;
			hw_gate_q              <= 1'b0;
			hw_rst_n_q             <= 1'b1;
		end else begin
			if (cfg_hit) begin
				// reserved bits 5:3 kept zero
				cfg_q <= cfg_wdata_i & 8'hc7; // R01 R02 R03 R04
			end
			if (fast_wr_i) begin
				soft_addr_gate_value_q <= fast_wdata_i[`AGK_FAST_GATE]; // R11
				fast_reset_request_q   <= fast_wdata_i[`AGK_FAST_RST];
			end
			// a fresh command other than write-output-port cancels a pending write-output-port
			if (kbc_cmd_wr_i) begin
				wr_out_pend_q <= (kbc_byte_i == `AGK_CMD_WR_OUT);
			end else if (kbc_data_wr_i && wr_out_pend_q) begin
				wr_out_pend_q <= 1'b0;
				hw_gate_q     <= kbc_byte_i[1]; // R05
				hw_rst_n_q    <= kbc_byte_i[0]; // R06
			end
		end
	end


	// controller pulse-reset command sequencer
	// a command arriving while busy is dropped inside the sequencer
	agk_pulse #(.CW(CW)) u_hw_pulse (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.start_i     (pulse_cmd && hw_kbd_reset_select), // R07
		.delay_cyc_i (delay_cyc),
		.pulse_cyc_i (pulse_cyc),
		.low_o       (hw_pulse_low)
	);


	// fast port reset request sequencer
	// shares the rate counts: delay is taken at start, pulse length when the wait ends, so a rate change during the wait hits this pulse
	agk_pulse #(.CW(CW)) u_fast_pulse (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.start_i     (fast_rise), // R12
		.delay_cyc_i (delay_cyc),
		.pulse_cyc_i (pulse_cyc),
		.low_o       (fast_pulse_low)
	);


	// controller side: firmware or snooping logic, never both
	// the pulse can only pull low, the stored level stays underneath it
	always @* begin
		ctl_gate  = hw_addr_gate_select ? hw_gate_q : sw_addr_gate_i; // R08 R03
		ctl_rst_n = hw_kbd_reset_select ? (hw_rst_n_q && !hw_pulse_low)
			: sw_kbd_reset_n_i; // R08 R04
	end


	// registered outputs keep combinational glitches off the pins
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_line20_gate_o     <= 1'b0;
			keyboard_reset_out_n_o <= 1'b1;
		end else if (fast_port_enable) begin
			addr_line20_gate_o     <= ctl_gate | soft_addr_gate_value_q; // R09 R15 R02
			keyboard_reset_out_n_o <= ctl_rst_n & !fast_pulse_low; // R09 R15
		end else begin
			addr_line20_gate_o     <= ctl_gate;
			keyboard_reset_out_n_o <= ctl_rst_n;
		end
	end
endmodule // agk_gate_reset

// ==== agk_gate_reset_checker.sv ====
`timescale 1ns/1ps
module agk_gate_reset_checker (
	input wire       clk_i,
	input wire       nrst_i,
	input wire [7:0] cfg_rdata_o,
	input wire [7:0] fast_rdata_o,
	input wire       kbc_cmd_wr_i,
	input wire       kbc_data_wr_i,
	input wire [7:0] kbc_byte_i,
	input wire       sw_addr_gate_i,
	input wire       sw_kbd_reset_n_i,
	input wire       addr_line20_gate_o,
	input wire       keyboard_reset_out_n_o,
	input wire [1:0] ctrl_clock_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// any other command cancels a pending output-port write
	reg d1_q;
	always @(posedge clk_i or negedge nrst_i)
		if (!nrst_i)
			d1_q <= 1'b0;
		else if (kbc_cmd_wr_i)
			d1_q <= kbc_byte_i == 8'hd1;
		else if (kbc_data_wr_i)
			d1_q <= 1'b0;
	a_fast_fixed: assert property (fast_rdata_o[7:2] == 6'h09)
		else $error("fast port fixed bits wrong");
	a_clk_sel: assert property (ctrl_clock_sel_o == cfg_rdata_o[7:6])
		else $error("clock select differs from config");
	a_sw_gate: assert property ((cfg_rdata_o[2:1] == 2'b00) [*2]
		|-> addr_line20_gate_o == $past(sw_addr_gate_i)) else $error("gate not software");
	a_sw_reset: assert property (({cfg_rdata_o[2], cfg_rdata_o[0]} == 2'b00) [*2]
		|-> keyboard_reset_out_n_o == $past(sw_kbd_reset_n_i)) else $error("reset not software");
	a_d1_gate: assert property (kbc_data_wr_i && d1_q && cfg_rdata_o[2:1] == 2'b01
		|-> ##2 addr_line20_gate_o == $past(kbc_byte_i[1], 2)) else $error("gate after d1");
	a_d1_reset: assert property (kbc_data_wr_i && d1_q && !cfg_rdata_o[2] && cfg_rdata_o[0]
		|-> ##2 keyboard_reset_out_n_o == $past(kbc_byte_i[0], 2)) else $error("reset after d1");
	a_fe_pulse: assert property (kbc_cmd_wr_i && kbc_byte_i == 8'hfe && cfg_rdata_o == 8'h03
		&& keyboard_reset_out_n_o |-> ##1 keyboard_reset_out_n_o [*8] ##76
		keyboard_reset_out_n_o ##[1:4] !keyboard_reset_out_n_o [*8]) else $error("fe pulse");
	a_fast_gate: assert property (cfg_rdata_o[2] && fast_rdata_o[1] |=> addr_line20_gate_o)
		else $error("fast gate not merged");
endmodule // agk_gate_reset_checker
bind agk_gate_reset agk_gate_reset_checker agk_gate_reset_checker_i (.clk_i, .nrst_i,
	.cfg_rdata_o, .fast_rdata_o, .kbc_cmd_wr_i, .kbc_data_wr_i, .kbc_byte_i, .sw_addr_gate_i,
	.sw_kbd_reset_n_i, .addr_line20_gate_o, .keyboard_reset_out_n_o, .ctrl_clock_sel_o);

// ==== agk_host_model.sv ====
`timescale 1ns/1ps
module agk_host_model (
	input  wire       clk_i,
	output reg  [3:0] strobe_o,
	output reg  [7:0] addr_o,
	output reg  [7:0] data_o
);
	initial begin
		strobe_o = 4'h0;
		addr_o = 8'h00;
		data_o = 8'h00;
	end
	// strobe kinds: 1 config, 2 fast port, 4 command, 8 data
	task wr(input [3:0] k, input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_i);
			#1;
			strobe_o = k;
			addr_o = a;
			data_o = d;
			@(posedge clk_i);
			#1;
			strobe_o = 4'h0;
			// released bus must not keep showing the last byte
			data_o = ~d;
		end
	endtask
endmodule // agk_host_model

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin \
	checked++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("wrong value at %0t: %h vs %h", $time, a, b); \
	end \
end
module testbench;
	logic       clk_i    = 1'b0;
	logic       nrst_i   = 1'b0;
	logic       sw_gate  = 1'b0;
	logic       sw_rst_n = 1'b1;
	logic [7:0] r;
	wire  [3:0] stb;
	wire  [7:0] addr, data, cfg_rd, fast_rd;
	wire  [1:0] sel;
	wire        gate, rst_n;
	int         n_mismatch = 0;
	int         checked = 0;
	int         i, hi, lo;
	initial forever #5 clk_i = ~clk_i;
	agk_host_model agk_host_model_i (.clk_i(clk_i), .strobe_o(stb), .addr_o(addr), .data_o(data));
	agk_gate_reset agk_gate_reset_i (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_wr_i(stb[0]),
		.cfg_addr_i(addr), .cfg_wdata_i(data), .cfg_rdata_o(cfg_rd), .fast_wr_i(stb[1]),
		.fast_wdata_i(data), .fast_rdata_o(fast_rd), .kbc_cmd_wr_i(stb[2]),
		.kbc_data_wr_i(stb[3]), .kbc_byte_i(data), .sw_addr_gate_i(sw_gate),
		.sw_kbd_reset_n_i(sw_rst_n), .addr_line20_gate_o(gate),
		.keyboard_reset_out_n_o(rst_n), .ctrl_clock_sel_o(sel));
	task wr(input [3:0] k, input [7:0] a, input [7:0] d);
		agk_host_model_i.wr(k, a, d);
	endtask
	// hi: cycles until reset seen low, lo: cycles it stays low
	task measure;
		begin
			hi = 0;
			lo = 0;
			while (rst_n === 1'b1 && hi < 400) begin
				@(negedge clk_i);
				hi++;
			end
			while (rst_n === 1'b0 && lo < 200) begin
				@(negedge clk_i);
				lo++;
			end
		end
	endtask
	task finish_test;
		begin
			$display("mismatches %0d comparisons %0d", n_mismatch, checked);
			if (n_mismatch == 0 && checked > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		r = $urandom(32'hce11b1b0);
		repeat (5) @(posedge clk_i);
		#1 nrst_i = 1'b1;
		`CHK(fast_rd, 8'h24)
		for (i = 0; i < 4; i++) begin
			r = $urandom;
			wr(1, 8'hf0, {i[1:0], 6'h3b});
			wr(1, 8'hf1, r);
			`CHK(cfg_rd, {i[1:0], 6'h03})
		end
		repeat (6) begin
			r = $urandom;
			wr(4, 0, 8'hd1);
			wr(8, 0, r);
			@(posedge clk_i);
			#1;
			`CHK(gate, r[1])
			`CHK(rst_n, r[0])
		end
		wr(4, 0, 8'hd1);
		wr(4, 0, 8'haa);
		wr(8, 0, ~r);
		`CHK(gate, r[1])
		wr(1, 8'hf0, 8'h03);
		wr(4, 0, 8'hd1);
		wr(8, 0, 8'h01);
		wr(4, 0, 8'hfe);
		measure();
		`CHK(hi > 84 && lo >= 36, 1'b1)
		wr(1, 8'hf0, 8'hc4);
		wr(2, 0, 8'h00);
		wr(2, 0, 8'h01);
		measure();
		`CHK(hi > 224 && lo >= 96, 1'b1)
		wr(2, 0, 8'h02);
		@(posedge clk_i);
		#1;
		`CHK({gate, fast_rd}, 9'h126)
		wr(1, 8'hf0, 8'h00);
		repeat (6) begin
			r = $urandom;
			sw_gate = r[0];
			sw_rst_n = r[1];
			repeat (3) @(posedge clk_i);
			#1;
			`CHK({gate, rst_n}, {r[0], r[1]})
		end
		finish_test();
	end
endmodule // testbench
